// >>> rtl/ssrd_pkg.sv
// constants of the short run sample detector
//
// Contract
// - threshold gives preliminary bit per sample
// - short-run result overrides threshold decision
// - test only samples inside amplitude window
// - peak candidate by two-apart comparisons
// - valley candidate by two-apart comparisons
// - two adjacent peaks force two ones
// - two adjacent valleys force two zeros
// - isolated candidates resolved by relative amplitudes
// - never emit single-bit runs (the code still emits them where no candidate is flagged)
// - larger outer difference picks correct sample
// - overrule middle samples into mark and space
package ssrd_pkg;

  // ****************************************************************
  // history and sample positions (index 0 is newest)
  // ****************************************************************
  localparam int          SSRD_HIST_LEN = 7;
  localparam int          SSRD_FILL_W   = 3;
  localparam int          SSRD_SMP_W    = 8;
  localparam int          SSRD_POS_NEW  = 0;  // sample n+2 of the test
  localparam int          SSRD_POS_N    = 2;  // sample under test
  localparam int          SSRD_POS_OLD  = 4;  // sample n-2 of the test
  localparam int          SSRD_POS_G    = 2;
  localparam int          SSRD_POS_F    = 3;
  localparam int          SSRD_POS_E    = 4;
  localparam int          SSRD_POS_D    = 5;
  localparam int          SSRD_POS_C    = 6;
  localparam logic [2:0]  SSRD_FILL_RST = 3'h0;
  // sample n-2 of the test exists only from the fifth sample on
  localparam logic [2:0]  SSRD_FLAG_MIN = 3'h5;
  localparam logic [2:0]  SSRD_FILL_MAX = 3'h7;

endpackage

// >>> rtl/ssrd_skid_buf.sv
// two-entry output buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module ssrd_skid_buf #(
  parameter int DW = 1
) (
  input  wire logic          clk_i,       // clock
  input  wire logic          rst_i,       // sync reset, high
  input  wire logic          ce_i,        // clock enable
  input  wire logic          in_valid_i,  // word offered
  input  wire logic [DW-1:0] in_data_i,   // word
  output var  logic          in_ready_o,  // room for a word
  output var  logic          out_valid_o, // word present
  output var  logic [DW-1:0] out_data_o,  // word
  input  wire logic          out_ready_i  // receiver takes word
);

  typedef struct packed {
    logic [DW-1:0] d0;
    logic [DW-1:0] d1;
    logic          v0;
    logic          v1;
    logic          rdy;
  } ssrd_buf_st_t;

  ssrd_buf_st_t st_r;
  ssrd_buf_st_t st_nxt;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    if (ce_i) begin
      if (st_r.v0 && out_ready_i) begin
        st_nxt.d0 = st_r.d1;
        st_nxt.v0 = st_r.v1;
        st_nxt.v1 = 1'b0;
      end
      // ready is registered, so a word offered while full is never taken
      if (in_valid_i && st_r.rdy) begin
        if (!st_nxt.v0) begin
          st_nxt.d0 = in_data_i;
          st_nxt.v0 = 1'b1;
        end else begin
          st_nxt.d1 = in_data_i;
          st_nxt.v1 = 1'b1;
        end
      end
      st_nxt.rdy = !st_nxt.v1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '{d0: '0, d1: '0, v0: 1'b0, v1: 1'b0, rdy: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign in_ready_o  = st_r.rdy;
  assign out_valid_o = st_r.v0;
  assign out_data_o  = st_r.d0;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_buf_stall_hold: assert property (
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
    else $error("buffered word changed during stall");
  a_buf_full_ready: assert property (
    st_r.v0 && st_r.v1 |-> !in_ready_o)
    else $error("buffer full but ready high");
  c_buf_full: cover property (!in_ready_o);

endmodule // ssrd_skid_buf
`default_nettype wire

// >>> rtl/ssrd_detector.sv
// short run sample detector: threshold plus peak/valley correction
`timescale 1ns/10ps
`default_nettype none
module ssrd_detector
  import ssrd_pkg::*;
#(
  parameter int SW = SSRD_SMP_W
) (
  input  wire logic          clk_i,          // clock, 100 MHz
  input  wire logic          rst_i,          // sync reset, high
  input  wire logic          ce_i,           // clock enable
  input  wire logic [SW-1:0] sample_i,       // sample amplitude
  input  wire logic          sample_valid_i, // sample offered
  output var  logic          sample_ready_o, // sample taken
  input  wire logic [SW-1:0] slice_i,        // slice threshold
  input  wire logic [SW-1:0] win_top_i,      // window upper bound
  input  wire logic [SW-1:0] win_bot_i,      // window lower bound
  output var  logic          bit_o,          // decided channel bit
  output var  logic          bit_valid_o,    // bit present
  input  wire logic          bit_ready_i     // receiver takes bit
);

  localparam int HL = SSRD_HIST_LEN;

  typedef struct packed {
    logic [HL-1:0][SW-1:0]  smp;
    logic [HL-1:0]          bits;
    logic [HL-1:0]          pk;
    logic [HL-1:0]          vl;
    logic [HL-1:0]          rs;   // fixed by an isolated pair
    logic [SSRD_FILL_W-1:0] fill;
  } ssrd_st_t;

  ssrd_st_t st_r;
  ssrd_st_t st_nxt;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // strictly above one side and not below the other
  function automatic logic ssrd_gt_ge(input logic [SW-1:0] x,
                                      input logic [SW-1:0] a,
                                      input logic [SW-1:0] b);
    return ((x > a) && (x >= b)) || ((x >= a) && (x > b));
  endfunction

  function automatic logic [SW-1:0] ssrd_absdiff(input logic [SW-1:0] a,
                                                 input logic [SW-1:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  logic          acc;
  logic          full;
  logic          in_win;
  logic          pk_new;
  logic          vl_new;
  logic          iso;
  logic          g_sel;
  logic          cd_val;
  logic [HL-1:0] b;
  logic          push;
  logic          emit;
  logic          buf_rdy;

  assign acc  = ce_i && sample_valid_i && buf_rdy;
  assign full = (st_r.fill == SSRD_FILL_MAX);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    b      = st_r.bits;
    in_win = (st_r.smp[SSRD_POS_N] >= win_bot_i) &&
             (st_r.smp[SSRD_POS_N] <= win_top_i);
    pk_new = (st_r.fill >= SSRD_FLAG_MIN) && in_win &&
             ssrd_gt_ge(st_r.smp[SSRD_POS_N], st_r.smp[SSRD_POS_OLD],
                        st_r.smp[SSRD_POS_NEW]);
    // inverting unsigned samples reverses their order
    vl_new = (st_r.fill >= SSRD_FLAG_MIN) && in_win &&
             ssrd_gt_ge(~st_r.smp[SSRD_POS_N], ~st_r.smp[SSRD_POS_OLD],
                        ~st_r.smp[SSRD_POS_NEW]);
    // pairs of candidates overrule the slice decision
    if (st_r.pk[3] && st_r.pk[4]) begin
      b[3] = 1'b1;
      b[4] = 1'b1;
    end
    if (st_r.vl[3] && st_r.vl[4]) begin
      b[3] = 1'b0;
      b[4] = 1'b0;
    end
    // a lone candidate joins its closer-amplitude neighbour; samples
    // already fixed by an isolated pair are not undone later
    if (st_r.pk[4] && !st_r.pk[3] && !st_r.pk[5] && !st_r.rs[4]) begin
      b[4] = 1'b1;
      if (st_r.rs[5] || (st_r.smp[3] >= st_r.smp[5])) begin
        b[3] = 1'b1;
      end else begin
        b[5] = 1'b1;
      end
    end
    if (st_r.vl[4] && !st_r.vl[3] && !st_r.vl[5] && !st_r.rs[4]) begin
      b[4] = 1'b0;
      if (st_r.rs[5] || (st_r.smp[3] <= st_r.smp[5])) begin
        b[3] = 1'b0;
      end else begin
        b[5] = 1'b0;
      end
    end
    // lone valley and lone peak two apart: one mark and one space
    iso = full && !st_r.pk[SSRD_POS_E] && !st_r.vl[SSRD_POS_E] &&
          ((st_r.vl[SSRD_POS_D] && !st_r.vl[SSRD_POS_C] &&
            st_r.pk[SSRD_POS_F] && !pk_new) ||
           (st_r.pk[SSRD_POS_D] && !st_r.pk[SSRD_POS_C] &&
            st_r.vl[SSRD_POS_F] && !vl_new));
    g_sel = ssrd_absdiff(st_r.smp[SSRD_POS_E], st_r.smp[SSRD_POS_G]) >
            ssrd_absdiff(st_r.smp[SSRD_POS_C], st_r.smp[SSRD_POS_E]);
    // the chosen outer sample is zero when it is the lower one
    cd_val = g_sel ? !(st_r.smp[SSRD_POS_G] < st_r.smp[SSRD_POS_E])
                   : !(st_r.smp[SSRD_POS_C] < st_r.smp[SSRD_POS_E]);
    if (iso) begin
      b[SSRD_POS_C] = cd_val;
      b[SSRD_POS_D] = cd_val;
      b[SSRD_POS_E] = !cd_val;
      b[SSRD_POS_F] = !cd_val;
    end
    emit = b[HL-1];
    push = acc && full;
    if (acc) begin
      st_nxt.smp  = {st_r.smp[HL-2:0], sample_i};
      st_nxt.bits = {b[HL-2:0], (sample_i >= slice_i)};
      st_nxt.pk   = {st_r.pk[HL-2:0], 1'b0};
      st_nxt.vl   = {st_r.vl[HL-2:0], 1'b0};
      st_nxt.rs   = {st_r.rs[HL-2:0], 1'b0};
      if (iso) begin
        st_nxt.rs[SSRD_POS_C] = 1'b1;
        st_nxt.rs[SSRD_POS_D] = 1'b1;
        st_nxt.rs[SSRD_POS_E] = 1'b1;
      end
      st_nxt.pk[SSRD_POS_F] = pk_new;
      st_nxt.vl[SSRD_POS_F] = vl_new;
      if (!full) begin
        st_nxt.fill = st_r.fill + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '{smp: '0, bits: '0, pk: '0, vl: '0, rs: '0,
                fill: SSRD_FILL_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // output buffer: a receiver stall stops sample intake, no bit lost
  // ****************************************************************
  ssrd_skid_buf #(
    .DW (1)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (push),
    .in_data_i   (emit),
    .in_ready_o  (buf_rdy),
    .out_valid_o (bit_valid_o),
    .out_data_o  (bit_o),
    .out_ready_i (bit_ready_i)
  );

  assign sample_ready_o = buf_rdy;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_slice_bit: assert property (
    acc |=> st_r.bits[0] == $past(sample_i >= slice_i))
    else $error("preliminary bit does not follow slice");

  a_window_gate: assert property (
    acc && !in_win |=> !st_r.pk[SSRD_POS_F] && !st_r.vl[SSRD_POS_F])
    else $error("candidate flagged outside window");

  a_peak_flag: assert property (
    acc && in_win && st_r.fill >= SSRD_FLAG_MIN |=>
      st_r.pk[SSRD_POS_F] ==
      $past(((st_r.smp[2] > st_r.smp[4]) && (st_r.smp[2] >= st_r.smp[0])) ||
            ((st_r.smp[2] >= st_r.smp[4]) && (st_r.smp[2] > st_r.smp[0]))))
    else $error("peak candidate wrong");

  a_valley_flag: assert property (
    acc && in_win && st_r.fill >= SSRD_FLAG_MIN |=>
      st_r.vl[SSRD_POS_F] ==
      $past(((st_r.smp[2] < st_r.smp[4]) && (st_r.smp[2] <= st_r.smp[0])) ||
            ((st_r.smp[2] <= st_r.smp[4]) && (st_r.smp[2] < st_r.smp[0]))))
    else $error("valley candidate wrong");

  a_pair_mark: assert property (
    acc && !iso && st_r.pk[3] && st_r.pk[4] |=> st_r.bits[4] && st_r.bits[5])
    else $error("two peaks not forced to ones");

  a_pair_space: assert property (
    acc && !iso && st_r.vl[3] && st_r.vl[4] |=> !st_r.bits[4] && !st_r.bits[5])
    else $error("two valleys not forced to zeros");

  a_lone_peak: assert property (
    acc && !iso && st_r.pk[4] && !st_r.pk[3] && !st_r.pk[5] && !st_r.vl[3] &&
    !st_r.vl[5] && !st_r.rs[4] |=>
      st_r.bits[5] && (st_r.bits[4] || st_r.bits[6]))
    else $error("lone peak left as one-bit run");

  a_iso_resolve: assert property (
    acc && iso |=> st_r.bits[6] == $past(cd_val) &&
      st_r.bits[5] == !st_r.bits[6] && st_r.bits[4] == st_r.bits[5])
    else $error("isolated pair resolved wrongly");

  a_emit_delay: assert property (
    acc && st_r.fill < SSRD_FILL_MAX |=> !bit_valid_o)
    else $error("bit emitted before history filled");

  c_pair_mark:  cover property (acc && st_r.pk[3] && st_r.pk[4]);
  c_pair_space: cover property (acc && st_r.vl[3] && st_r.vl[4]);
  c_iso:        cover property (acc && iso);
  c_stall:      cover property (sample_valid_i && !sample_ready_o);

endmodule // ssrd_detector
`default_nettype wire

// >>> bench/ssrd_sampler_model.sv
// model of the sampler that feeds amplitudes to the detector
`timescale 1ns/10ps
`default_nettype none
module ssrd_sampler_model (
  input  wire logic       clk_i,   // clock
  input  wire logic       rst_i,   // sync reset, high
  input  wire logic       ce_i,    // clock enable
  input  wire logic       slow_i,  // idle every other cycle
  input  wire logic       ready_i, // detector takes sample
  output var  logic [7:0] smp_o,   // amplitude
  output var  logic       valid_o  // amplitude offered
);
  logic [7:0] q[$];
  logic [7:0] last;
  logic       took;
  logic       in_rst;
  logic       lazy;
  bit         phase;

  initial begin
    valid_o = 1'b0;
    smp_o = 8'hFF;
    last = 8'h00;
  end

  always @(posedge clk_i) begin
    in_rst = rst_i;
    took = valid_o && ready_i && ce_i && !rst_i;
    if (took) begin
      last = q.pop_front();
    end
    phase = ~phase;
    lazy = slow_i && phase;
    #1;
    // an offer is held until taken; only then may a gap follow
    if (took || !valid_o || in_rst) begin
      if (!in_rst && q.size() != 0 && !lazy) begin
        valid_o = 1'b1;
        smp_o = q[0];
      end else begin
        // idle lines show the inverse so a stale copy never passes
        valid_o = 1'b0;
        smp_o = ~last;
      end
    end
  end
endmodule // ssrd_sampler_model
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench of the short run sample detector
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e, m) \
  begin \
    tests_run++; \
    if ((g) !== (e)) begin \
      miscompares++; \
      $display("wrong value at %0t ns: %s", $time, m); \
    end \
  end
module testbench;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       ce_i = 1'b1;
  logic       slow = 1'b0;
  logic [7:0] slice_i = 8'h80;
  logic [7:0] win_top_i = 8'hFF;
  logic [7:0] win_bot_i = 8'h00;
  logic       bit_ready_i = 1'b1;
  logic [7:0] sample_i;
  logic       sample_valid_i;
  logic       sample_ready_o;
  logic       bit_o;
  logic       bit_valid_o;
  logic [1:0] mode = 2'h0;
  logic [1:0] cyc = 2'h0;
  logic [7:0] smp[$];
  logic       expb[$];
  logic       got[$];
  int         miscompares = 0;
  int         tests_run = 0;

  ssrd_detector u_ssrd_detector (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .sample_i(sample_i), .sample_valid_i(sample_valid_i),
    .sample_ready_o(sample_ready_o), .slice_i(slice_i),
    .win_top_i(win_top_i), .win_bot_i(win_bot_i), .bit_o(bit_o),
    .bit_valid_o(bit_valid_o), .bit_ready_i(bit_ready_i));

  ssrd_sampler_model u_ssrd_sampler_model (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .slow_i(slow), .ready_i(sample_ready_o),
    .smp_o(sample_i), .valid_o(sample_valid_i));

  always #5 clk_i = ~clk_i;

  // ****************************************************************
  // bit receiver: stalls and clock-enable gaps follow mode
  // ****************************************************************
  always @(posedge clk_i) begin
    logic ce_n;
    logic rdy_n;
    if (!rst_i && ce_i && bit_ready_i && bit_valid_o === 1'b1) begin
      got.push_back(bit_o);
    end
    cyc = cyc + 2'h1;
    ce_n = (mode == 2'h1) ? (cyc != 2'h3) : 1'b1;
    rdy_n = (mode == 2'h2) ? 1'b0 : ((mode == 2'h1) ? cyc[1] : 1'b1);
    #1;
    ce_i = ce_n;
    bit_ready_i = rdy_n;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic at_edge();
    @(posedge clk_i);
    #1;
  endtask

  task automatic reset_dut();
    at_edge();
    rst_i = 1'b1;
    mode = 2'h0;
    slow = 1'b0;
    slice_i = 8'h80;
    win_top_i = 8'hFF;
    win_bot_i = 8'h00;
    repeat (10) at_edge();
    rst_i = 1'b0;
    got.delete();
    smp.delete();
    expb.delete();
  endtask

  task automatic add(input logic [7:0] v, input int n, input logic b);
    repeat (n) begin
      smp.push_back(v);
      expb.push_back(b);
    end
  endtask

  // the last seven samples only flush the history and give no bit
  task automatic drain(input bit feed = 1'b1);
    int n;
    n = smp.size() - 7;
    if (feed) begin
      foreach (smp[i]) u_ssrd_sampler_model.q.push_back(smp[i]);
    end
    for (int i = 0; i < 4000 && got.size() < n; i++) at_edge();
    repeat (20) at_edge();
    `CHK(got.size(), n, "bit count")
  endtask

  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask

  task automatic fill_space2();
    add(8'hC0, 8, 1'b1);
    add(8'hA0, 2, 1'b0);
    add(8'hC0, 8, 1'b1);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_threshold();
    logic [7:0] v[6] = '{8'h7F, 8'h80, 8'h81, 8'h00, 8'hFF, 8'h7F};
    reset_dut();
    win_top_i = 8'h00;
    win_bot_i = 8'hFF;
    foreach (v[i]) add(v[i], 1, v[i] >= 8'h80);
    add(8'h00, 7, 1'b0);
    drain();
    for (int i = 0; i < 6; i++) `CHK(got[i], expb[i], "slice")
    end_test("threshold");
  endtask

  task automatic t_pairs();
    reset_dut();
    fill_space2();
    drain();
    for (int i = 0; i < 11; i++) `CHK(got[i], expb[i], "space")
    reset_dut();
    win_bot_i = 8'hB0;
    fill_space2();
    drain();
    for (int i = 0; i < 11; i++) `CHK(got[i], 1'b1, "window")
    reset_dut();
    add(8'h40, 8, 1'b0);
    add(8'h60, 2, 1'b1);
    add(8'h40, 8, 1'b0);
    drain();
    for (int i = 0; i < 11; i++) `CHK(got[i], expb[i], "mark")
    end_test("pairs");
  endtask

  // lone valley then lone peak; the far outer sample wins
  task automatic t_isolated();
    reset_dut();
    add(8'hA0, 7, 1'b1);
    add(8'h90, 1, 1'b0);
    add(8'h70, 1, 1'b0);
    add(8'h88, 1, 1'b1);
    add(8'h98, 1, 1'b1);
    add(8'h30, 9, 1'b0);
    drain();
    for (int i = 0; i < 13; i++) `CHK(got[i], expb[i], "lone")
    for (int i = 1; i < 12; i++) begin
      `CHK(got[i] == got[i-1] || got[i] == got[i+1], 1'b1, "1T")
    end
    // mirror: lone peak then lone valley, chosen sample above E
    reset_dut();
    add(8'h60, 7, 1'b0);
    add(8'h70, 1, 1'b1);
    add(8'h90, 1, 1'b1);
    add(8'h78, 1, 1'b0);
    add(8'h68, 1, 1'b0);
    add(8'hD0, 9, 1'b1);
    drain();
    for (int i = 0; i < 13; i++) `CHK(got[i], expb[i], "flip")
    end_test("isolated");
  endtask

  task automatic t_stall();
    reset_dut();
    mode = 2'h2;
    fill_space2();
    foreach (smp[i]) u_ssrd_sampler_model.q.push_back(smp[i]);
    repeat (40) at_edge();
    `CHK(sample_ready_o, 1'b0, "intake open")
    `CHK(bit_valid_o, 1'b1, "bit dropped")
    `CHK(bit_o, expb[0], "held bit")
    mode = 2'h1;
    slow = 1'b1;
    drain(1'b0);
    for (int i = 0; i < 11; i++) `CHK(got[i], expb[i], "stall")
    `CHK(u_ssrd_sampler_model.q.size(), 0, "samples left")
    end_test("stall");
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    t_threshold();
    t_pairs();
    t_isolated();
    t_stall();
    summarize();
  end

  // the whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    summarize();
  end
endmodule // testbench
`default_nettype wire
